// >>> pcs_sequencer.v
// Power-cycle sequencer: backup-store wait, I/O bring-up, power-down save.
// Assumes all inputs synchronous to clock; rst is the power-up reset.
// The I/O controllers answer each step request with a one-cycle io_ack.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_defines.vh"
module pcs_sequencer #(
  parameter [31:0] LOSS_CYC = `PCS_LOSS_CYC,
  parameter [31:0] WAIT_CYC = `PCS_WAIT_CYC
) (
  input  wire                      clock,
  input  wire                      rst,
  input  wire                      supply_ok,
  input  wire                      base_ok,
  input  wire                      cart_ok,
  input  wire                      charged,
  input  wire                      end_of_life,
  input  wire                      nv_keep,
  input  wire                      io_ack,
  input  wire                      io_mismatch,
  input  wire [`PCS_RACK_W-1:0]    rack_mask,
  input  wire                      save_done,
  output reg                       io_req_ff,
  output reg  [`PCS_STEP_W-1:0]    io_step_ff,
  output reg                       io_fault_log_ff,
  output reg  [`PCS_RACK_W-1:0]    slots_pending_ff,
  output reg                       outputs_default_ff,
  output reg                       run_app_ff,
  output reg                       use_stored_ff,
  output reg                       save_req_ff,
  output reg                       nv_keep_wr_ff,
  output reg                       nv_keep_data_ff,
  output reg                       backup_failed_flag_ff,
  output reg                       backup_low_flag_ff,
  output reg                       backup_fault_ff,
  output reg  [`PCS_CLASS_N-1:0]   retain_ff
);
  localparam [2:0] S_WAKE   = 3'h0;
  localparam [2:0] S_WAIT   = 3'h1;
  localparam [2:0] S_IOINIT = 3'h2;
  localparam [2:0] S_RUN    = 3'h3;
  localparam [2:0] S_SAVE   = 3'h4;
  localparam [2:0] S_HALT   = 3'h5;

  localparam [`PCS_CLASS_N-1:0] RETAIN = `PCS_RETAIN_MASK;
  localparam [31:0] WAIT_CYC32 = WAIT_CYC[31:0];

  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg        wait_failed_ff;
  reg        cart_q_ff;
  reg        timer_start_ff;
  wire       power_down;
  wire       wait_expired;

  pcs_power_filter #(
    .LOSS_CYC (LOSS_CYC)
  ) u_filter (
    .clock         (clock),
    .rst           (rst),
    .supply_ok     (supply_ok),
    .power_down_ff (power_down)
  );

  pcs_charge_timer #(
    .WAIT_CYC (WAIT_CYC32)
  ) u_timer (
    .clock      (clock),
    .rst        (rst),
    .start      (timer_start_ff),
    .stop       (charged),
    .expired_ff (wait_expired)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_WAKE: begin
        if (!base_ok)
          nxt_state = S_IOINIT;
        else
          nxt_state = S_WAIT;
      end
      S_WAIT: begin
        if (charged || wait_expired)
          nxt_state = S_IOINIT;
      end
      S_IOINIT: begin
        if (io_ack && io_step_ff == `PCS_STEP_APPLY)
          nxt_state = S_RUN;
      end
      S_RUN: begin
        nxt_state = S_RUN;
      end
      S_SAVE: begin
        if (save_done)
          nxt_state = S_HALT;
      end
      S_HALT: begin
        nxt_state = S_HALT;
      end
      default: begin
        nxt_state = S_WAKE;
      end
    endcase
    // Supply loss preempts every live state; the save runs only once
    if (power_down && state_ff != S_SAVE && state_ff != S_HALT)
      nxt_state = S_SAVE;
  end

  always @(posedge clock) begin
    if (rst) begin
      state_ff <= S_WAKE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      io_req_ff          <= 1'b0;
      io_step_ff         <= `PCS_STEP_OUTDFLT;
      io_fault_log_ff    <= 1'b0;
      slots_pending_ff   <= {`PCS_RACK_W{1'b0}};
      outputs_default_ff <= 1'b1;
      run_app_ff         <= 1'b0;
      use_stored_ff      <= 1'b0;
      save_req_ff        <= 1'b0;
      nv_keep_wr_ff      <= 1'b0;
      nv_keep_data_ff    <= 1'b0;
      backup_fault_ff    <= 1'b0;
      wait_failed_ff     <= 1'b0;
      timer_start_ff     <= 1'b0;
    end else begin
      io_fault_log_ff <= 1'b0;
      nv_keep_wr_ff   <= 1'b0;
      backup_fault_ff <= 1'b0;
      timer_start_ff  <= 1'b0;
      case (state_ff)
        S_WAKE: begin
          // Only the saved decision matters, not what was plugged in
          // while unpowered
          use_stored_ff <= 1'b0;
          if (!base_ok) begin
            wait_failed_ff  <= 1'b1;
            backup_fault_ff <= 1'b1;
          end else begin
            timer_start_ff <= 1'b1;
          end
          if (nxt_state == S_IOINIT) begin
            io_req_ff  <= 1'b1;
            io_step_ff <= `PCS_STEP_OUTDFLT;
          end
        end
        S_WAIT: begin
          if (charged) begin
            use_stored_ff <= nv_keep;
          end else if (wait_expired) begin
            use_stored_ff   <= 1'b0;
            wait_failed_ff  <= 1'b1;
            backup_fault_ff <= 1'b1;
          end
          if (nxt_state == S_IOINIT) begin
            io_req_ff  <= 1'b1;
            io_step_ff <= `PCS_STEP_OUTDFLT;
          end
        end
        S_IOINIT: begin
          if (io_ack) begin
            case (io_step_ff)
              `PCS_STEP_RACKS: begin
                slots_pending_ff <= slots_pending_ff | rack_mask;
              end
              `PCS_STEP_COMPARE: begin
                io_fault_log_ff <= io_mismatch;
              end
              default: begin
              end
            endcase
            if (io_step_ff == `PCS_STEP_APPLY) begin
              io_req_ff          <= 1'b0;
              outputs_default_ff <= 1'b0;
              run_app_ff         <= 1'b1;
            end else begin
              // Steps run in a fixed order; each waits for its answer
              io_step_ff <= io_step_ff + 3'h1;
            end
          end
        end
        S_RUN: begin
          if (cart_q_ff && !cart_ok)
            backup_fault_ff <= 1'b1;
          if (charged && base_ok && cart_ok)
            wait_failed_ff <= 1'b0;
        end
        S_SAVE: begin
          save_req_ff <= !save_done;
        end
        default: begin
        end
      endcase
      if (nxt_state == S_SAVE && state_ff != S_SAVE) begin
        // Outputs fall back to default while the image is written
        io_req_ff          <= 1'b0;
        outputs_default_ff <= 1'b1;
        run_app_ff         <= 1'b0;
        save_req_ff        <= 1'b1;
        nv_keep_wr_ff      <= 1'b1;
        nv_keep_data_ff    <= base_ok & cart_ok & charged;
      end
    end
  end

  // Flags track the store live, with the power-up verdict folded in
  always @(posedge clock) begin
    if (rst) begin
      cart_q_ff             <= 1'b0;
      backup_failed_flag_ff <= 1'b1;
      backup_low_flag_ff    <= 1'b1;
    end else begin
      cart_q_ff <= cart_ok;
      backup_failed_flag_ff <= !base_ok || !cart_ok
                               || wait_failed_ff;
      backup_low_flag_ff    <= !base_ok || !cart_ok
                               || wait_failed_ff || end_of_life;
    end
  end

  // Memory classes restored from the image; the mask is fixed per class
  genvar gi;
  generate
    for (gi = 0; gi < `PCS_CLASS_N; gi = gi + 1) begin : g_ret
      always @(posedge clock) begin
        if (rst)
          retain_ff[gi] <= 1'b0;
        else
          retain_ff[gi] <= use_stored_ff & RETAIN[gi];
      end
    end
  endgenerate
  // Classes with a zero mask bit are cleared on every power-up
endmodule
`default_nettype wire

// >>> pcs_defines.vh
// Constants for the power-cycle and backup-store sequencer.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Notes on behaviour
// - Supply absent longer than 15 ms means the system is powering down.
// - Inputs need no setup; outputs are commanded to their default state.
// - Query bus transmitters; add reported racks and slots to pending set.
// - Connect each controller bus, collect config, log each mismatch.
// - After comparing, send each controller its module list.
// - Once controllers are ready, replace factory settings with app settings.
// - On power loss the store holds supply while memory is copied.
// - On restore with store attached, hold the application until full charge.
// - After full charge, resume from the memory saved at the last loss.
// - Keep user memory only if store attached and charged at power-down.
// - Absent or slow store ends the wait by timeout; run without it.
// - Flags: both clear ok, both set failed, low only means end of life.
// - Cartridge pulled in normal operation reports a failed-store fault.
// - Bad base at power-up boots at once, drops memory, raises fault.
// - Good base, no charge within 90 s: resume without memory, raise fault.
// - Working backup keeps program, tables, data memories, retentive bits.
// - Temporary, non-retentive coil and system bits are never kept.
// - Attaching or detaching the store while unpowered changes nothing.
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

`define PCS_CLK_HZ        25000000
`define PCS_LOSS_MS       15
`define PCS_WAIT_S        90
`define PCS_LOSS_CYC      ((`PCS_LOSS_MS * `PCS_CLK_HZ) / 1000)
`define PCS_WAIT_CYC      (32'd`PCS_WAIT_S * 32'd`PCS_CLK_HZ)

`define PCS_STEP_W        3
`define PCS_STEP_OUTDFLT  3'h0
`define PCS_STEP_RACKS    3'h1
`define PCS_STEP_CONNECT  3'h2
`define PCS_STEP_COMPARE  3'h3
`define PCS_STEP_MODLIST  3'h4
`define PCS_STEP_APPLY    3'h5

`define PCS_RACK_W        8
`define PCS_CLASS_N       12
// Program, faults, checksums, overrides, registers, analog, inputs,
// retentive outputs, retentive internals kept; temp, coils, system not.
`define PCS_RETAIN_MASK   12'h1FF

`endif

// >>> pcs_power_filter.v
// Supply dropout qualifier: flags power-down after a long enough gap.
// Assumes supply_ok is already synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_defines.vh"
module pcs_power_filter #(
  parameter [31:0] LOSS_CYC = `PCS_LOSS_CYC
) (
  input  wire clock,
  input  wire rst,
  input  wire supply_ok,
  output reg  power_down_ff
);
  reg [31:0] gap_ff;

  // Short glitches restart the count; a real loss is sticky until reset
  always @(posedge clock) begin
    if (rst) begin
      gap_ff        <= 32'h0;
      power_down_ff <= 1'b0;
    end else if (supply_ok) begin
      gap_ff <= 32'h0;
    end else begin
      if (gap_ff != 32'hFFFFFFFF)
        gap_ff <= gap_ff + 32'h1;
      if (gap_ff >= LOSS_CYC)
        power_down_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> pcs_charge_timer.v
// Charge-wait timer: one-cycle expiry pulse a fixed time after start.
// Assumes start is a one-cycle request from the sequencer; stop is the charged level.
`timescale 1ns/1ns
`default_nettype none
module pcs_charge_timer #(
  parameter [31:0] WAIT_CYC = 32'h0
) (
  input  wire clock,
  input  wire rst,
  input  wire start,
  input  wire stop,
  output reg  expired_ff
);
  reg [31:0] left_ff;
  reg        run_ff;

  always @(posedge clock) begin
    if (rst) begin
      left_ff    <= 32'h0;
      run_ff     <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (start) begin
        left_ff <= WAIT_CYC;
        run_ff  <= 1'b1;
      end else if (stop) begin
        run_ff <= 1'b0;
      end else if (run_ff) begin
        if (left_ff <= 32'h1) begin
          run_ff     <= 1'b0;
          expired_ff <= 1'b1;
        end else begin
          left_ff <= left_ff - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> pcs_sequencer_monitor.sv
// Checker for the power-cycle sequencer, bound to its top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module pcs_sequencer_monitor #(
  parameter [31:0] LOSS_CYC = 32'h14
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        supply_ok,
  input wire logic        base_ok,
  input wire logic        io_ack,
  input wire logic        io_mismatch,
  input wire logic [7:0]  rack_mask,
  input wire logic        io_req_ff,
  input wire logic [2:0]  io_step_ff,
  input wire logic        io_fault_log_ff,
  input wire logic [7:0]  slots_pending_ff,
  input wire logic        outputs_default_ff,
  input wire logic        run_app_ff,
  input wire logic        save_req_ff,
  input wire logic        nv_keep_wr_ff,
  input wire logic        backup_failed_flag_ff,
  input wire logic        backup_low_flag_ff,
  input wire logic        backup_fault_ff,
  input wire logic [11:0] retain_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] low_ff;
  wire logic   stp = io_req_ff & io_ack;
  // Counts low supply samples so a save can be tied to a long dropout
  always @(posedge clock) begin
    low_ff <= (rst | supply_ok) ? 32'h0 : low_ff + 32'h1;
  end
  chk_loss_gap: assert property ($rose(save_req_ff) |-> low_ff >= LOSS_CYC)
    else $error("save began on a short dropout");
  chk_save_entry: assert property ($rose(save_req_ff) |-> nv_keep_wr_ff &&
    !run_app_ff && outputs_default_ff && !io_req_ff)
    else $error("save entry outputs wrong");
  chk_step_next: assert property (stp && io_step_ff < 3'h5 |=>
    io_step_ff == $past(io_step_ff) + 3'h1)
    else $error("step did not advance");
  chk_mism_log: assert property (stp && io_step_ff == 3'h3 && io_mismatch
    |=> io_fault_log_ff)
    else $error("mismatch not logged");
  chk_rack_add: assert property (stp && io_step_ff == 3'h1 |=>
    (slots_pending_ff & $past(rack_mask)) == $past(rack_mask))
    else $error("racks not added");
  chk_app_after: assert property (stp && io_step_ff == 3'h5 |=>
    run_app_ff && !outputs_default_ff)
    else $error("no run after last step");
  chk_run_outs: assert property (run_app_ff |-> !outputs_default_ff)
    else $error("outputs defaulted in run");
  chk_flag_pair: assert property (backup_failed_flag_ff |-> backup_low_flag_ff)
    else $error("illegal flag pair");
  chk_base_fault: assert property ($fell(rst) && !base_ok |-> ##[1:3]
    backup_fault_ff)
    else $error("no fault for bad base");
  chk_retain_cls: assert property (retain_ff[11:9] == 3'h0)
    else $error("volatile class retained");
  cover property (stp && io_step_ff == 3'h5);
  cover property ($rose(save_req_ff));
  cover property ($rose(backup_fault_ff));
endmodule
bind pcs_sequencer pcs_sequencer_monitor #(.LOSS_CYC(LOSS_CYC)) i_mon (
  .clock, .rst, .supply_ok, .base_ok, .io_ack, .io_mismatch, .rack_mask,
  .io_req_ff, .io_step_ff, .io_fault_log_ff, .slots_pending_ff,
  .outputs_default_ff, .run_app_ff, .save_req_ff, .nv_keep_wr_ff,
  .backup_failed_flag_ff, .backup_low_flag_ff, .backup_fault_ff, .retain_ff);
`default_nettype wire

// >>> pcs_store_model.sv
// Model of the backup store and the I/O controllers.
// Assumes good is high only while base and cartridge are fine.
`timescale 1ns/1ns
`default_nettype none
module pcs_store_model (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       good,
  input wire logic       io_req_ff,
  input wire logic [2:0] io_step_ff,
  input wire logic       save_req_ff,
  output logic           charged,
  output logic           io_ack,
  output logic           io_mismatch,
  output logic [7:0]     rack_mask,
  output logic           save_done
);
  int cnt_ff;
  always @(posedge clock) begin
    cnt_ff <= rst ? 0 : cnt_ff + 1;
    charged <= good && cnt_ff > 30;
    io_ack <= io_req_ff && !io_ack;
    io_mismatch <= io_req_ff && io_step_ff == 3'h3;
    // Off its step the mask carries junk so a late sample shows
    rack_mask <= (io_req_ff && io_step_ff == 3'h1) ? 8'h05 : 8'hFA;
    save_done <= save_req_ff && cnt_ff[2];
  end
endmodule
`default_nettype wire

// >>> pcs_sequencer_tb.sv
// Self-checking bench for the power-cycle sequencer with a store model.
// Assumes short counts: LOSS_CYC of 20 and WAIT_CYC of 100 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_defines.vh"
module pcs_sequencer_tb;
  logic clock, rst, supply_ok, base_ok, cart_ok, end_of_life, nv_keep;
  logic charged, io_ack, io_mismatch, save_done;
  logic [7:0] rack_mask, slots_pending_ff;
  logic [2:0] io_step_ff;
  logic [11:0] retain_ff;
  logic io_req_ff, io_fault_log_ff, outputs_default_ff, run_app_ff;
  logic use_stored_ff, save_req_ff, nv_keep_wr_ff, nv_keep_data_ff;
  logic backup_failed_flag_ff, backup_low_flag_ff, backup_fault_ff;
  int n_fail, num_checks, nf, nlog, nwr;
  pcs_sequencer #(.LOSS_CYC(32'h14), .WAIT_CYC(32'h64)) i_pcs_sequencer (
    .clock, .rst, .supply_ok, .base_ok, .cart_ok, .charged, .end_of_life,
    .nv_keep, .io_ack, .io_mismatch, .rack_mask, .save_done, .io_req_ff,
    .io_step_ff, .io_fault_log_ff, .slots_pending_ff, .outputs_default_ff,
    .run_app_ff, .use_stored_ff, .save_req_ff, .nv_keep_wr_ff,
    .nv_keep_data_ff, .backup_failed_flag_ff, .backup_low_flag_ff,
    .backup_fault_ff, .retain_ff);
  pcs_store_model i_pcs_store_model (.clock, .rst, .good(base_ok & cart_ok),
    .io_req_ff, .io_step_ff, .save_req_ff, .charged, .io_ack, .io_mismatch,
    .rack_mask, .save_done);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    nf <= rst ? 0 : nf + backup_fault_ff;
    nlog <= rst ? 0 : nlog + io_fault_log_ff;
    nwr <= rst ? 0 : nwr + nv_keep_wr_ff;
  end
  task report_and_stop;
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task ck(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task go(input logic b, input logic c, input logic k);
    @(posedge clock);
    rst <= 1'b1;
    base_ok <= b;
    cart_ok <= c;
    nv_keep <= k;
    supply_ok <= 1'b1;
    end_of_life <= 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
  endtask
  task wait_run(output int n);
    n = 0;
    while (run_app_ff !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    ck(n < 400, "never ran");
  endtask
  task s_good;
    int n;
    go(1'b1, 1'b1, 1'b1);
    wait_run(n);
    ck(n > 30, "ran before charge");
    ck(use_stored_ff === 1'b1, "memory dropped");
    ck(retain_ff === `PCS_RETAIN_MASK, "retain classes");
    ck(slots_pending_ff === 8'h05, "racks");
    ck(nlog === 1, "mismatch log");
    ck(outputs_default_ff === 1'b0, "outputs held");
    ck({backup_failed_flag_ff, backup_low_flag_ff} === 2'b00, "flags");
    go(1'b1, 1'b1, 1'b0);
    wait_run(n);
    ck(use_stored_ff === 1'b0, "keep ignored");
  endtask
  task s_bad(input logic b);
    int n;
    go(b, ~b, 1'b1);
    wait_run(n);
    ck(b ? n > 100 : n < 30, "boot time");
    ck(use_stored_ff === 1'b0, "stale memory");
    ck(retain_ff === 12'h000, "retained without store");
    ck(nf === 1, "fault count");
    ck({backup_failed_flag_ff, backup_low_flag_ff} === 2'b11, "flags");
  endtask
  task s_events;
    int n;
    go(1'b1, 1'b1, 1'b1);
    wait_run(n);
    @(posedge clock);
    end_of_life <= 1'b1;
    repeat (3) @(negedge clock);
    ck({backup_failed_flag_ff, backup_low_flag_ff} === 2'b01, "eol");
    @(posedge clock);
    end_of_life <= 1'b0;
    cart_ok <= 1'b0;
    repeat (4) @(negedge clock);
    ck(nf === 1, "pull fault");
    ck({backup_failed_flag_ff, backup_low_flag_ff} === 2'b11, "pull");
  endtask
  task s_down;
    int n;
    for (int i = 0; i < 2; i++) begin
      go(1'b1, i == 0, 1'b1);
      wait_run(n);
      @(posedge clock);
      supply_ok <= 1'b0;
      repeat (10) @(posedge clock);
      supply_ok <= 1'b1;
      repeat (30) @(negedge clock);
      ck(save_req_ff === 1'b0, "short gap saved");
      @(posedge clock);
      supply_ok <= 1'b0;
      repeat (23) @(negedge clock);
      ck(save_req_ff === 1'b1, "no save");
      ck(outputs_default_ff === 1'b1 && run_app_ff === 1'b0, "run");
      ck(nv_keep_data_ff === (i == 0), "keep");
      repeat (12) @(negedge clock);
      ck(save_req_ff === 1'b0, "save stuck");
      ck(nwr === 1, "keep writes");
    end
  endtask
  initial begin
    rst = 1'b1;
    supply_ok = 1'b1;
    base_ok = 1'b1;
    cart_ok = 1'b1;
    end_of_life = 1'b0;
    nv_keep = 1'b0;
    n_fail = 0;
    num_checks = 0;
    s_good;
    s_bad(1'b0);
    s_bad(1'b1);
    s_events;
    s_down;
    report_and_stop;
  end
  initial begin
    #(40 * 8000);
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
